// ===== hw/apms_defines.svh
// timing, register offsets and device addresses for the power-mode sequencer
// assumes a 200 MHz system clock and a page 0 device register space
`ifndef APMS_DEFINES_SVH
`define APMS_DEFINES_SVH
// clock rate and least waits in microseconds
`define APMS_CLK_MHZ 200
`define APMS_T_INIT_US 2000
`define APMS_T_WAKE_US 1000
`define APMS_T_SLEEP_US 6000
`define APMS_T_POLL_US 1000
`define APMS_T_DOWN_US 10000
`define APMS_T_OFF_US 100000
// device registers, page 0
`define APMS_R_SWRST 8'h01
`define APMS_V_SWRST 8'h01
`define APMS_R_SLEEP 8'h02
`define APMS_R_CH0 8'h28
`define APMS_R_PWR 8'h78
`define APMS_R_STAT 8'h7a
`define APMS_STAT_HI 7
`define APMS_STAT_LO 5
`define APMS_STAT_ASLEEP 3'h4
// host register byte offsets
`define APMS_A_CTRL 5'h00
`define APMS_A_STAT 5'h04
`define APMS_A_CHLO 5'h08
`define APMS_A_CHHI 5'h0c
`define APMS_A_PWR 5'h10
`define APMS_A_SLP 5'h14
// control bits
`define APMS_C_UP 0
`define APMS_C_WAKE 1
`define APMS_C_SLEEP 2
`define APMS_C_DOWN 3
`define APMS_C_SLOW 4
`define APMS_C_ERRCLR 7
// reset values
`define APMS_RST_CH 32'h0000_0000
`define APMS_RST_PWR 8'h00
`define APMS_RST_WAKEV 8'h00
`define APMS_RST_SLEEPV 8'h01
`endif

// ===== hw/apms_pkg.sv
// types shared by the power-mode sequencer
// assumes apms_defines.svh carries all numbers
package apms_pkg;
  typedef enum logic [10:0] {
    ST_OFF        = 11'h001,
    ST_RAMP       = 11'h002,
    ST_INIT       = 11'h004,
    ST_SLEEP      = 11'h008,
    ST_WAKE_WAIT  = 11'h010,
    ST_CFG        = 11'h020,
    ST_ACTIVE     = 11'h040,
    ST_SLEEP_WAIT = 11'h080,
    ST_POLL       = 11'h100,
    ST_DOWN_WAIT  = 11'h200,
    ST_XFER       = 11'h400
  } apms_state_t;
  typedef logic [24:0] apms_cnt_t;
endpackage

// ===== hw/apms_timer.sv
// loadable down-counter timing the least waits of the sequencer
// assumes load is a one-cycle pulse; done is low during the load cycle
module apms_timer
  import apms_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire apms_pkg::apms_cnt_t val,
  output logic done
);
  apms_cnt_t cnt_q;

  // count down to zero after each load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 25'h1;
    end
  end

  // stale zero is masked while a new wait is loaded
  assign done = (cnt_q == '0) && !load;
endmodule // apms_timer

// ===== hw/apms_seq.sv
// host-side power-mode sequencer for a stereo audio converter
// assumes an external control-bus engine (ctl_*) and an audio clock generator gated by asi_clk_en
// How it works
// - wait 2 ms after supplies before anything
// - wake: write sleep register, sleep cleared
// - wait 1 ms after the wake write
// - then write the eight channel-enable registers
// - then power up the converter register
// - start frame and bit clocks after wake
// - sleep: write sleep register, sleep set
// - wait 6 ms after the sleep write
// - stop clocks only when status field 100
// - rewake: wake write, wait, clocks, no reprogram
// - bus traffic only after supplies stable
// - allow 2 ms before the first transaction
// - allow 10 ms before removing supplies
// - hold 100 ms between power-down and power-up
// - slow ramp: software reset goes first
// - device inputs held static while supplies off
`include "apms_defines.svh"
module apms_seq #(
  parameter int unsigned INIT_CYC = `APMS_T_INIT_US * `APMS_CLK_MHZ,
  parameter int unsigned WAKE_CYC = `APMS_T_WAKE_US * `APMS_CLK_MHZ,
  parameter int unsigned SLEEP_CYC = `APMS_T_SLEEP_US * `APMS_CLK_MHZ,
  parameter int unsigned POLL_CYC = `APMS_T_POLL_US * `APMS_CLK_MHZ,
  parameter int unsigned DOWN_CYC = `APMS_T_DOWN_US * `APMS_CLK_MHZ,
  parameter int unsigned OFF_CYC = `APMS_T_OFF_US * `APMS_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic sup_en,
  input wire logic sup_good,
  output logic ctl_req,
  output logic ctl_rnw,
  output logic [7:0] ctl_addr,
  output logic [7:0] ctl_wdata,
  input wire logic ctl_ack,
  input wire logic [7:0] ctl_rdata,
  output logic asi_clk_en
);
  import apms_pkg::*;

  logic rst_meta_q, rst_q;
  logic wait_q;
  logic [31:0] rdata_q, chlo_q, chhi_q;
  logic [7:0] pwr_q, wakev_q, sleepv_q, stat_q, addr_q, wdata_q;
  logic slow_q, err_q, up_pend_q, cfgd_q, sup_q, req_q, rnw_q, clk_q, tmr_ld_q;
  apms_state_t st_q, ret_q;
  logic [3:0] idx_q;
  apms_cnt_t tmr_val_q;
  logic tmr_done, acc, wr_ctrl;
  logic [3:0] cmd;
  logic [7:0] ch_byte;
  logic [63:0] ch_all;

  // reset released through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // byte-lane merge for configuration words
  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // an access completes at the edge where waitrequest is low
  assign acc = (avs_read || avs_write) && !wait_q;
  assign wr_ctrl = acc && avs_write && avs_address == `APMS_A_CTRL && avs_byteenable[0];
  assign cmd = wr_ctrl ? avs_writedata[3:0] : 4'h0;

  // one wait cycle per access, read data registered
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
      case (avs_address)
        `APMS_A_CTRL: rdata_q <= {27'h0, slow_q, 4'h0};
        `APMS_A_STAT: rdata_q <= {err_q, 4'h0, sup_q, clk_q, cfgd_q, 5'h0, stat_q[`APMS_STAT_HI:`APMS_STAT_LO],
                                  5'h0, st_q};
        `APMS_A_CHLO: rdata_q <= chlo_q;
        `APMS_A_CHHI: rdata_q <= chhi_q;
        `APMS_A_PWR: rdata_q <= {24'h0, pwr_q};
        `APMS_A_SLP: rdata_q <= {16'h0, sleepv_q, wakev_q};
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      wait_q <= 1'b1;
    end
  end

  // configuration registers written by software
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      chlo_q <= `APMS_RST_CH;
      chhi_q <= `APMS_RST_CH;
      pwr_q <= `APMS_RST_PWR;
      wakev_q <= `APMS_RST_WAKEV;
      sleepv_q <= `APMS_RST_SLEEPV;
      slow_q <= 1'b0;
    end else if (acc && avs_write) begin
      case (avs_address)
        `APMS_A_CTRL: if (avs_byteenable[0]) slow_q <= avs_writedata[`APMS_C_SLOW];
        `APMS_A_CHLO: chlo_q <= bmerge(chlo_q, avs_writedata, avs_byteenable);
        `APMS_A_CHHI: chhi_q <= bmerge(chhi_q, avs_writedata, avs_byteenable);
        `APMS_A_PWR: if (avs_byteenable[0]) pwr_q <= avs_writedata[7:0];
        `APMS_A_SLP: begin
          if (avs_byteenable[0]) wakev_q <= avs_writedata[7:0];
          if (avs_byteenable[1]) sleepv_q <= avs_writedata[15:8];
        end
        default: ;
      endcase
    end
  end

  // refused commands set a sticky flag; a new refusal wins over the clear
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      err_q <= 1'b0;
    end else if ((cmd[`APMS_C_UP] && st_q != ST_OFF) ||
                 ((cmd[`APMS_C_WAKE] || cmd[`APMS_C_DOWN]) && st_q != ST_SLEEP) ||
                 (cmd[`APMS_C_SLEEP] && st_q != ST_ACTIVE)) begin
      err_q <= 1'b1;
    end else if (wr_ctrl && avs_writedata[`APMS_C_ERRCLR]) begin
      err_q <= 1'b0;
    end
  end

  assign ch_all = {chhi_q, chlo_q};
  assign ch_byte = ch_all[idx_q[2:0]*8 +: 8];

  apms_timer u_tmr (
    .sys_clk(sys_clk),
    .rst_n(rst_q),
    .load(tmr_ld_q),
    .val(tmr_val_q),
    .done(tmr_done)
  );

  // sequencing state machine and device-facing outputs
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      st_q <= ST_OFF;
      ret_q <= ST_OFF;
      idx_q <= 4'h0;
      sup_q <= 1'b0;
      req_q <= 1'b0;
      rnw_q <= 1'b0;
      addr_q <= 8'h0;
      wdata_q <= 8'h0;
      clk_q <= 1'b0;
      cfgd_q <= 1'b0;
      stat_q <= 8'h0;
      up_pend_q <= 1'b0;
      tmr_ld_q <= 1'b0;
      tmr_val_q <= '0;
    end else begin
      tmr_ld_q <= 1'b0;
      if (cmd[`APMS_C_UP] && st_q == ST_OFF) up_pend_q <= 1'b1;
      case (st_q)
        ST_OFF: if (up_pend_q && tmr_done) begin
          up_pend_q <= 1'b0;
          sup_q <= 1'b1;
          st_q <= ST_RAMP;
        end
        ST_RAMP: if (sup_good) begin
          tmr_val_q <= apms_cnt_t'(INIT_CYC);
          tmr_ld_q <= 1'b1;
          st_q <= ST_INIT;
        end
        ST_INIT: if (tmr_done) begin
          cfgd_q <= 1'b0;
          if (slow_q) begin
            req_q <= 1'b1;
            rnw_q <= 1'b0;
            addr_q <= `APMS_R_SWRST;
            wdata_q <= `APMS_V_SWRST;
            ret_q <= ST_SLEEP;
            st_q <= ST_XFER;
          end else begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: if (cmd[`APMS_C_WAKE]) begin
          req_q <= 1'b1;
          rnw_q <= 1'b0;
          addr_q <= `APMS_R_SLEEP;
          wdata_q <= wakev_q;
          tmr_val_q <= apms_cnt_t'(WAKE_CYC);
          ret_q <= ST_WAKE_WAIT;
          st_q <= ST_XFER;
        end else if (cmd[`APMS_C_DOWN]) begin
          tmr_val_q <= apms_cnt_t'(DOWN_CYC);
          tmr_ld_q <= 1'b1;
          st_q <= ST_DOWN_WAIT;
        end
        ST_WAKE_WAIT: if (tmr_done) begin
          clk_q <= 1'b1;
          idx_q <= 4'h0;
          st_q <= cfgd_q ? ST_ACTIVE : ST_CFG;
        end
        ST_CFG: begin
          req_q <= 1'b1;
          rnw_q <= 1'b0;
          addr_q <= idx_q[3] ? `APMS_R_PWR : `APMS_R_CH0 + {5'h0, idx_q[2:0]};
          wdata_q <= idx_q[3] ? pwr_q : ch_byte;
          idx_q <= idx_q + 4'h1;
          cfgd_q <= idx_q[3];
          ret_q <= idx_q[3] ? ST_ACTIVE : ST_CFG;
          st_q <= ST_XFER;
        end
        ST_ACTIVE: if (cmd[`APMS_C_SLEEP]) begin
          req_q <= 1'b1;
          rnw_q <= 1'b0;
          addr_q <= `APMS_R_SLEEP;
          wdata_q <= sleepv_q;
          tmr_val_q <= apms_cnt_t'(SLEEP_CYC);
          ret_q <= ST_SLEEP_WAIT;
          st_q <= ST_XFER;
        end
        ST_SLEEP_WAIT: if (tmr_done) begin
          req_q <= 1'b1;
          rnw_q <= 1'b1;
          addr_q <= `APMS_R_STAT;
          ret_q <= ST_POLL;
          st_q <= ST_XFER;
        end
        ST_POLL: if (stat_q[`APMS_STAT_HI:`APMS_STAT_LO] == `APMS_STAT_ASLEEP) begin
          clk_q <= 1'b0;
          st_q <= ST_SLEEP;
        end else begin
          tmr_val_q <= apms_cnt_t'(POLL_CYC);
          tmr_ld_q <= 1'b1;
          st_q <= ST_SLEEP_WAIT;
        end
        ST_DOWN_WAIT: if (tmr_done) begin
          sup_q <= 1'b0;
          tmr_val_q <= apms_cnt_t'(OFF_CYC);
          tmr_ld_q <= 1'b1;
          st_q <= ST_OFF;
        end
        ST_XFER: if (ctl_ack) begin
          req_q <= 1'b0;
          if (rnw_q) stat_q <= ctl_rdata;
          tmr_ld_q <= 1'b1;
          st_q <= ret_q;
        end
        default: st_q <= ST_OFF;
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign sup_en = sup_q;
  assign ctl_req = req_q;
  assign ctl_rnw = rnw_q;
  assign ctl_addr = addr_q;
  assign ctl_wdata = wdata_q;
  assign asi_clk_en = clk_q;

  // elapsed-time counters read only by the checks below
  apms_cnt_t good_t_q, r2_t_q, slp_t_q, off_t_q;
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      good_t_q <= '0;
      r2_t_q <= '0;
      slp_t_q <= '0;
      off_t_q <= '1;
    end else begin
      good_t_q <= !sup_good ? '0 : good_t_q + apms_cnt_t'(good_t_q != '1);
      r2_t_q <= (ctl_ack && req_q && addr_q == `APMS_R_SLEEP) ? '0 : r2_t_q + apms_cnt_t'(r2_t_q != '1);
      slp_t_q <= (st_q != ST_SLEEP && st_q != ST_DOWN_WAIT) ? '0 : slp_t_q + apms_cnt_t'(slp_t_q != '1);
      off_t_q <= sup_q ? '0 : off_t_q + apms_cnt_t'(off_t_q != '1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_q);

  property p_init_wait;
    $rose(req_q) |-> sup_good && good_t_q >= apms_cnt_t'(INIT_CYC);
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("bus used before init wait");

  property p_wake_wait;
    $rose(clk_q) |-> r2_t_q >= apms_cnt_t'(WAKE_CYC);
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("clocks started before wake wait");

  property p_sleep_wait;
    $fell(clk_q) |-> r2_t_q >= apms_cnt_t'(SLEEP_CYC);
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("clocks stopped before sleep wait");

  property p_stop_status;
    $fell(clk_q) |-> $past(stat_q[`APMS_STAT_HI:`APMS_STAT_LO]) == `APMS_STAT_ASLEEP;
  endproperty
  a_stop_status: assert property (p_stop_status) else $error("clocks stopped without sleep status");

  property p_down_wait;
    $fell(sup_q) |-> slp_t_q >= apms_cnt_t'(DOWN_CYC) && !clk_q;
  endproperty
  a_down_wait: assert property (p_down_wait) else $error("supplies removed too early");

  property p_off_gap;
    $rose(sup_q) |-> off_t_q >= apms_cnt_t'(OFF_CYC);
  endproperty
  a_off_gap: assert property (p_off_gap) else $error("power-up too soon after power-down");

  property p_swrst_first;
    st_q == ST_INIT && tmr_done && slow_q |=> req_q && !rnw_q && addr_q == `APMS_R_SWRST;
  endproperty
  a_swrst_first: assert property (p_swrst_first) else $error("software reset not first");

  property p_static_pins;
    (req_q || clk_q) |-> sup_q && sup_good;
  endproperty
  a_static_pins: assert property (p_static_pins) else $error("pins toggle while supplies off");

  property p_req_hold;
    req_q && !ctl_ack |=> req_q && $stable(addr_q) && $stable(wdata_q) && $stable(rnw_q);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");

  property p_pwr_last;
    $rose(req_q) && addr_q == `APMS_R_PWR |-> idx_q == 4'h9 && cfgd_q;
  endproperty
  a_pwr_last: assert property (p_pwr_last) else $error("converter powered before channels");

  property p_avs_wait;
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q;
  endproperty
  a_avs_wait: assert property (p_avs_wait) else $error("bus answer timing wrong");
endmodule // apms_seq

// ===== verification/apms_dev_model.sv
// device-side model: supplies, control-bus slave and page 0 registers
// assumes one sys_clk; each request is answered ACK_DLY+1 cycles late
module apms_dev_model #(
  parameter int ACK_DLY = 3
) (
  input wire logic sys_clk,
  input wire logic sup_en,
  output logic sup_good,
  input wire logic ctl_req,
  input wire logic ctl_rnw,
  input wire logic [7:0] ctl_addr,
  input wire logic [7:0] ctl_wdata,
  output logic ctl_ack,
  output logic [7:0] ctl_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [256];
  logic [7:0] last_q;
  logic [7:0] rv;
  logic [4:0] sup_q;
  logic [7:0] wlog [$];
  int cyc, wait_n, ramp_n, n_rd, t_up, t_first, t_wr2, t_rd, bad_req;
  initial begin
    sup_good = 1'b0;
    ctl_ack = 1'b0;
    ctl_rdata = 8'h00;
    last_q = 8'h00;
    sup_q = 5'h00;
    t_first = -1;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // supplies report good six cycles after enable
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sup_q <= {sup_q[3:0], sup_en};
    sup_good <= sup_en & sup_q[4];
    if (sup_en & sup_q[4] & !sup_good) t_up <= cyc;
  end
  // slave: late ack, stale data shown inverted when idle
  always @(posedge sys_clk) begin
    ctl_ack <= 1'b0;
    ctl_rdata <= ~last_q;
    if (ctl_req & !sup_good) bad_req <= bad_req + 1;
    // first request after each supply turn-on; cleared while supplies are off
    if (!sup_en) t_first <= -1;
    else if (ctl_req & !ctl_ack & t_first < 0) t_first <= cyc;
    if (ctl_req & !ctl_ack) begin
      wait_n <= wait_n + 1;
      if (wait_n == ACK_DLY) begin
        wait_n <= 0;
        ctl_ack <= 1'b1;
        if (ctl_rnw) begin
          // status 100 only once ramp-down and power-down are over
          rv = (ctl_addr != 8'h7a) ? regs[ctl_addr] : (regs[2][0] && ramp_n == 0) ? 8'h80 : 8'h20;
          ctl_rdata <= rv;
          last_q <= rv;
          if (ctl_addr == 8'h7a && ramp_n > 0) ramp_n <= ramp_n - 1;
          if (n_rd == 0) t_rd <= cyc;
          n_rd <= n_rd + 1;
        end else begin
          regs[ctl_addr] <= ctl_wdata;
          wlog.push_back(ctl_addr);
          if (ctl_addr == 8'h02) begin
            t_wr2 <= cyc;
            n_rd <= 0;
            ramp_n <= 32'(ctl_wdata[0]);
          end
        end
      end
    end
  end
endmodule // apms_dev_model

// ===== verification/tb.sv
// self-checking bench for the power-mode sequencer
// assumes apms_dev_model stands in for supplies, bus engine and device
`include "apms_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import apms_pkg::*;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, sup_en, sup_good;
  logic ctl_req, ctl_rnw, ctl_ack, asi_clk_en;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [7:0] ctl_addr, ctl_wdata, ctl_rdata, a;
  logic [1:0] en_q = 2'b00;
  logic [63:0] ch = 64'h8877_ff55_4433_2211;
  int fail_count, total_checks, t_on, t_stop, t_off, t_en;
  // shortened waits in cycles, shared by the instance and the expected gaps
  localparam int T_INIT = 40;
  localparam int T_WAKE = 20;
  localparam int T_SLEEP = 60;
  localparam int T_POLL = 10;
  localparam int T_DOWN = 50;
  localparam int T_OFF = 100;
  apms_seq #(.INIT_CYC(T_INIT), .WAKE_CYC(T_WAKE), .SLEEP_CYC(T_SLEEP), .POLL_CYC(T_POLL), .DOWN_CYC(T_DOWN),
    .OFF_CYC(T_OFF)) apms_seq_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sup_en(sup_en), .sup_good(sup_good), .ctl_req(ctl_req), .ctl_rnw(ctl_rnw), .ctl_addr(ctl_addr),
    .ctl_wdata(ctl_wdata), .ctl_ack(ctl_ack), .ctl_rdata(ctl_rdata), .asi_clk_en(asi_clk_en));
  apms_dev_model apms_dev_model_i (.sys_clk(sys_clk), .sup_en(sup_en), .sup_good(sup_good),
    .ctl_req(ctl_req), .ctl_rnw(ctl_rnw), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_ack(ctl_ack), .ctl_rdata(ctl_rdata));
  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // edge times of audio clocks and supplies
  always @(posedge sys_clk) begin
    en_q <= {asi_clk_en, sup_en};
    if (asi_clk_en & !en_q[1]) t_on <= apms_dev_model_i.cyc;
    if (!asi_clk_en & en_q[1]) t_stop <= apms_dev_model_i.cyc;
    if (!sup_en & en_q[0]) t_off <= apms_dev_model_i.cyc;
    if (sup_en & !en_q[0]) t_en <= apms_dev_model_i.cyc;
  end
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) begin
      fail_count++;
      final_report;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // poll the state field until it shows s
  task automatic wait_st(input apms_state_t s);
    int n;
    n = 0;
    do begin
      bus(1'b0, `APMS_A_STAT, 32'h0);
      n++;
    end while (rd[10:0] !== s && n < 400);
    chk("state", 32'(rd[10:0]), 32'(s));
    if (n >= 400) final_report;
  endtask
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // reset values, unmapped place, byte lanes
    bus(1'b0, `APMS_A_STAT, 32'h0);
    chk("stat reset", rd, 32'h0000_0001);
    bus(1'b1, 5'h18, 32'hffff_ffff);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b0, `APMS_A_SLP, 32'h0);
    chk("slp reset", rd, 32'h0000_0100);
    bus(1'b1, `APMS_A_CHLO, 32'h4433_2211);
    bus(1'b1, `APMS_A_CHHI, 32'h8877_6655);
    avs_byteenable <= 4'h2;
    bus(1'b1, `APMS_A_CHHI, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    bus(1'b1, `APMS_A_PWR, 32'h0000_005a);
    // power-up with slow supply ramp
    bus(1'b1, `APMS_A_CTRL, 32'h11);
    bus(1'b0, `APMS_A_CTRL, 32'h0);
    chk("slow flag", rd, 32'h0000_0010);
    wait_st(ST_SLEEP);
    chk("first write", 32'(apms_dev_model_i.wlog[0]), 32'(`APMS_R_SWRST));
    chk("init gap", 32'(apms_dev_model_i.t_first - apms_dev_model_i.t_up >= T_INIT), 32'h1);
    // refused command sets and clears the error flag
    bus(1'b1, `APMS_A_CTRL, 32'h04);
    bus(1'b0, `APMS_A_STAT, 32'h0);
    chk("err set", 32'(rd[31]), 32'h1);
    // refusal and clear in one write: the refusal wins
    bus(1'b1, `APMS_A_CTRL, 32'h84);
    bus(1'b0, `APMS_A_STAT, 32'h0);
    chk("err set wins", 32'(rd[31]), 32'h1);
    bus(1'b1, `APMS_A_CTRL, 32'h80);
    bus(1'b0, `APMS_A_STAT, 32'h0);
    chk("err clr", 32'(rd[31]), 32'h0);
    // first wake: order, data, wait before clocks
    apms_dev_model_i.wlog.delete();
    bus(1'b1, `APMS_A_CTRL, 32'h02);
    wait_st(ST_ACTIVE);
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? `APMS_R_SLEEP : (i == 9) ? `APMS_R_PWR : 8'(`APMS_R_CH0 + i - 1);
      chk("write order", 32'(apms_dev_model_i.wlog[i]), 32'(a));
    end
    for (int j = 0; j < 8; j++) begin
      chk("chan byte", 32'(apms_dev_model_i.regs[40 + j]), 32'(ch[8 * j +: 8]));
    end
    chk("pwr byte", 32'(apms_dev_model_i.regs[120]), 32'h5a);
    chk("wake value", 32'(apms_dev_model_i.regs[2]), 32'h0);
    chk("wake gap", 32'(t_on - apms_dev_model_i.t_wr2 >= T_WAKE), 32'h1);
    // sleep: wait, poll past one busy status, stop clocks
    bus(1'b1, `APMS_A_CTRL, 32'h04);
    wait_st(ST_SLEEP);
    chk("status field", 32'(rd[18:16]), 32'h4);
    chk("clocks off", 32'(rd[25]), 32'h0);
    chk("status reads", 32'(apms_dev_model_i.n_rd), 32'h2);
    chk("sleep value", 32'(apms_dev_model_i.regs[2]), 32'h1);
    chk("sleep gap", 32'(apms_dev_model_i.t_rd - apms_dev_model_i.t_wr2 >= T_SLEEP), 32'h1);
    // second wake: no reprogramming, settings kept
    apms_dev_model_i.wlog.delete();
    bus(1'b1, `APMS_A_CTRL, 32'h02);
    wait_st(ST_ACTIVE);
    chk("rewake writes", 32'(apms_dev_model_i.wlog.size()), 32'h1);
    chk("kept byte", 32'(apms_dev_model_i.regs[45]), 32'hff);
    chk("rewake gap", 32'(t_on - apms_dev_model_i.t_wr2 >= T_WAKE), 32'h1);
    // sleep, power down, power up again
    bus(1'b1, `APMS_A_CTRL, 32'h04);
    wait_st(ST_SLEEP);
    bus(1'b1, `APMS_A_CTRL, 32'h08);
    wait_st(ST_OFF);
    chk("supply off", 32'(rd[26]), 32'h0);
    chk("down gap", 32'(t_off - t_stop >= T_DOWN), 32'h1);
    bus(1'b1, `APMS_A_CTRL, 32'h01);
    wait_st(ST_SLEEP);
    chk("off gap", 32'(t_en - t_off >= T_OFF), 32'h1);
    chk("early req", 32'(apms_dev_model_i.bad_req), 32'h0);
    final_report;
  end
endmodule // tb
